/* File: dv/dbbd_link_monitor.sv */
// Concurrent checks on the link between the two ends
module dbbd_link_monitor #(
  parameter int PW = 200,
  parameter int DC = 10
) (
  // Clock and reset
  input wire logic             clk,
  input wire logic             sys_rst,
  // Link signals
  input dbbd_pkg::dbbd_level_e dev_drive,
  input dbbd_pkg::dbbd_level_e host_drive,
  input wire logic             dev_discharge,
  input wire logic             pattern_bit,
  input wire logic             pattern_en,
  input wire logic             vbus_above_discharged,
  input wire logic             vbus_probe_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] pat_r;
  logic [15:0] prb_r;
  logic [15:0] dis_r;
  logic        full;
  logic        prb;
  assign full = dev_drive == dbbd_pkg::DBBD_LVL_FULL;
  assign prb  = dev_drive == dbbd_pkg::DBBD_LVL_PROBE;
  // Run lengths; counters instead of long repetitions
  always_ff @(posedge clk) begin
    pat_r <= (sys_rst || !pattern_en) ? '0 : pat_r + 1'b1;
    prb_r <= (sys_rst || !prb) ? '0 : prb_r + 1'b1;
    dis_r <= (sys_rst || !dev_discharge) ? '0 : dis_r + 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_full_after_bits: assert property ($rose(full) |-> pat_r >= 128)
    else $error("full supply before enough pattern bits");
  chk_full_from_probe: assert property ($rose(full) |-> $past(prb))
    else $error("full supply not entered from probe");
  chk_probe_limit: assert property (prb |-> prb_r <= PW)
    else $error("probe held too long");
  chk_discharge_follows: assert property ($fell(prb) && !full |-> dev_discharge)
    else $error("no discharge after unanswered probe");
  chk_discharge_limit: assert property (dev_discharge |-> dis_r <= DC)
    else $error("discharge held too long");
  chk_pattern_toggle: assert property (pattern_en && $past(pattern_en) |->
    pattern_bit != $past(pattern_bit))
    else $error("pattern bit did not alternate");
  chk_pattern_cause: assert property ($rose(pattern_en) |-> vbus_probe_level)
    else $error("pattern started without probe");
  chk_host_quiet: assert property (!vbus_above_discharged |-> ##[0:2] !pattern_en)
    else $error("pattern kept on a discharged bus");
  chk_sink_no_probe: assert property (host_drive == dbbd_pkg::DBBD_LVL_FULL |-> !prb)
    else $error("probe applied on a powered bus");
  cov_full: cover property ($rose(full));
  cov_discharge: cover property ($rose(dev_discharge));
  cov_host_src: cover property (host_drive == dbbd_pkg::DBBD_LVL_FULL);
  cov_backoff: cover property ($fell(full) && dev_discharge);
endmodule : dbbd_link_monitor

/* File: dv/tb_top.sv */
// Self-checking bench joining both ends of the probe link
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PI = 20;
  localparam int PW = 200;
  localparam int DC = 10;
  localparam int SD = 20;
  localparam int HP = 150;
  localparam int RW = 300;
  logic clk, sys_rst, enable, gate_en, peer, wants, willing, ready;
  logic probing, full_on, sink_mode, source_mode, caps;
  logic power_up, sourcing, pat_act;
  int   mismatches, total_checks, cyc, n, k;
  dbbd_link_if link ();
  // Bench stands in for the bus: any drive lifts VBUS
  assign link.vbus_above_discharged = link.dev_drive != dbbd_pkg::DBBD_LVL_NONE ||
                                      link.host_drive != dbbd_pkg::DBBD_LVL_NONE;
  assign link.vbus_probe_level = link.dev_drive == dbbd_pkg::DBBD_LVL_PROBE;
  assign link.vbus_full_supply_level = link.dev_drive == dbbd_pkg::DBBD_LVL_FULL ||
                                       link.host_drive == dbbd_pkg::DBBD_LVL_FULL;
  dbbd_dev #(.PROBE_INTERVAL_CYC(PI), .PATTERN_WAIT_CYC(PW), .DISCHARGE_CYC(DC),
    .READY_WAIT_CYC(RW), .PATTERN_MIN_BITS(128)) dbbd_dev_i (.clk(clk), .sys_rst(sys_rst),
    .enable(enable), .presence_gate_en(gate_en), .peer_present(peer), .probing(probing),
    .full_supply_on(full_on), .sink_mode(sink_mode), .source_mode(source_mode),
    .send_source_caps(caps), .link(link.dev));
  dbbd_host #(.START_DEADLINE_CYC(SD), .POWER_WAIT_CYC(HP)) dbbd_host_i (.clk(clk),
    .sys_rst(sys_rst), .wants_power(wants), .willing_source(willing), .logic_ready(ready),
    .power_up_rest(power_up), .sourcing(sourcing), .pattern_active(pat_act),
    .link(link.host));
  dbbd_link_monitor #(.PW(PW), .DC(DC)) dbbd_link_monitor_i (.clk(clk), .sys_rst(sys_rst),
    .dev_drive(link.dev_drive), .host_drive(link.host_drive),
    .dev_discharge(link.dev_discharge), .pattern_bit(link.pattern_bit),
    .pattern_en(link.pattern_en), .vbus_above_discharged(link.vbus_above_discharged),
    .vbus_probe_level(link.vbus_probe_level));
  always #5 clk = ~clk;
  // Hang guard; whole run needs under two thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  function automatic logic sig(input int s);
    case (s)
      0: return probing;
      1: return pat_act;
      2: return full_on;
      4: return link.dev_discharge;
      default: return power_up;
    endcase
  endfunction : sig
  // Counts cycles until an output reaches lvl, bounded
  task automatic wait_lvl(input int s, input logic lvl, input int lim);
    n = 0;
    @(negedge clk);
    while (sig(s) !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_lvl
  task automatic do_reset();
    @(posedge clk);
    sys_rst <= 1'b1;
    {enable, gate_en, peer, wants, willing, ready} <= '0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
  endtask : do_reset
  task automatic s_no_peer();
    do_reset();
    enable <= 1'b1;
    wait_lvl(0, 1'b1, PI + 8);
    check(n >= PI && n <= PI + 4, 1'b1);
    check(16'(link.host_drive), 16'(dbbd_pkg::DBBD_LVL_NONE));
    k = 0;
    n = 0;
    while (probing === 1'b1 && n < PW + 8) begin
      @(negedge clk);
      n++;
      if (full_on !== 1'b0) k++;
    end
    check(n >= PW && n <= PW + 1, 1'b1);
    check(link.dev_discharge, 1'b1);
    wait_lvl(0, 1'b1, DC + PI + 12);
    check({probing, full_on}, 2'b10);
    check(16'(k), 16'h0000);
  endtask : s_no_peer
  task automatic s_full();
    do_reset();
    wants <= 1'b1;
    enable <= 1'b1;
    wait_lvl(0, 1'b1, PI + 8);
    wait_lvl(1, 1'b1, SD + 4);
    check(n <= SD, 1'b1);
    wait_lvl(2, 1'b1, 200);
    k = n;
    check(n >= 128 && n <= 140, 1'b1);
    check(full_on, 1'b1);
    wait_lvl(3, 1'b1, HP);
    check(k + n >= HP - 3 && k + n <= HP + 3, 1'b1);
    @(posedge clk);
    ready <= 1'b1;
    wait_lvl(1, 1'b0, 4);
    check(pat_act, 1'b0);
    k = 0;
    repeat (6) begin
      @(negedge clk);
      if (caps === 1'b1) k++;
    end
    check({k[1:0], source_mode}, 3'b011);
  endtask : s_full
  // Peer never gets ready: ready-wait expiry backs off and peer goes quiet
  task automatic s_no_ready();
    do_reset();
    wants <= 1'b1;
    enable <= 1'b1;
    wait_lvl(0, 1'b1, PI + 8);
    wait_lvl(2, 1'b1, PW);
    check(full_on, 1'b1);
    wait_lvl(4, 1'b1, RW + 8);
    check(n >= RW - 1 && n <= RW + 1, 1'b1);
    check({full_on, probing}, 2'h0);
    @(negedge clk);
    check({pat_act, power_up}, 2'h0);
  endtask : s_no_ready
  task automatic s_sink();
    do_reset();
    willing <= 1'b1;
    enable <= 1'b1;
    repeat (PI + 10) @(negedge clk);
    check({sourcing, sink_mode, probing}, 3'b110);
  endtask : s_sink
  task automatic s_gate();
    do_reset();
    gate_en <= 1'b1;
    enable <= 1'b1;
    k = 0;
    repeat (3 * PI) begin
      @(negedge clk);
      if (probing !== 1'b0) k++;
    end
    check(16'(k), 16'h0000);
    @(posedge clk);
    peer <= 1'b1;
    wait_lvl(0, 1'b1, 2 * PI + 8);
    check(probing, 1'b1);
    repeat (30) @(negedge clk);
    check({pat_act, full_on, sourcing}, 3'b000);
  endtask : s_gate
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {enable, gate_en, peer, wants, willing, ready} = '0;
    s_no_peer();
    s_full();
    s_no_ready();
    s_sink();
    s_gate();
    finish_test();
  end
endmodule : tb_top

/* File: hw/dbbd_defs.svh */
// Timing counts and widths shared by both ends of the probe link
`ifndef DBBD_DEFS_SVH
`define DBBD_DEFS_SVH
`define DBBD_CLK_MHZ            100
`define DBBD_PROBE_INTERVAL_US  100
`define DBBD_PROBE_INTERVAL_CYC (`DBBD_PROBE_INTERVAL_US * `DBBD_CLK_MHZ)
`define DBBD_PATTERN_WAIT_US    50
`define DBBD_PATTERN_WAIT_CYC   (`DBBD_PATTERN_WAIT_US * `DBBD_CLK_MHZ)
`define DBBD_DISCHARGE_US       10
`define DBBD_DISCHARGE_CYC      (`DBBD_DISCHARGE_US * `DBBD_CLK_MHZ)
`define DBBD_READY_WAIT_US      200
`define DBBD_READY_WAIT_CYC     (`DBBD_READY_WAIT_US * `DBBD_CLK_MHZ)
`define DBBD_START_DEADLINE_US  20
`define DBBD_START_DEADLINE_CYC (`DBBD_START_DEADLINE_US * `DBBD_CLK_MHZ)
`define DBBD_POWER_WAIT_US      40
`define DBBD_POWER_WAIT_CYC     (`DBBD_POWER_WAIT_US * `DBBD_CLK_MHZ)
`define DBBD_PATTERN_MIN_BITS   128
`define DBBD_CNT_W              24
`endif

/* File: hw/dbbd_dev.sv */
// Backpowering end: probes VBUS, detects the pattern, raises full supply
// How it works
// - Probe VBUS repeatedly while full supply absent
// - Unpowered peer answers probe with pattern
// - Pattern seen: drive full supply
// - No pattern: never drive full supply
// - Unanswered probe: repeat probe cycle
// - Each probe is limited in time
// - Optional peer presence check before probing
// - Unpowered peer starts driving nothing
// - Peer starts pattern within start deadline
// - Peer assumes full supply after wait time
// - Peer ready: stops the pattern
// - Backpowering end optionally has dead-peer detection
// - Peer leaves VBUS undriven at first
// - Initial step starts probe interval timer
// - Willing peer without probe becomes source
// - Unwilling peer without probe keeps waiting
// - VBUS seen high before probe: become sink
// - Pattern needs 128 alternating bits
// - Timer expiry: probe, start pattern wait
// - Wait expiry: bounded discharge, then restart
// - Pattern stops after full supply: act source

`include "dbbd_defs.svh"

module dbbd_dev #(
  parameter int unsigned PROBE_INTERVAL_CYC = `DBBD_PROBE_INTERVAL_CYC,
  parameter int unsigned PATTERN_WAIT_CYC   = `DBBD_PATTERN_WAIT_CYC,
  parameter int unsigned DISCHARGE_CYC      = `DBBD_DISCHARGE_CYC,
  parameter int unsigned READY_WAIT_CYC     = `DBBD_READY_WAIT_CYC,
  parameter int unsigned PATTERN_MIN_BITS   = `DBBD_PATTERN_MIN_BITS
) (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   sys_rst,
  // User side
  input  wire logic   enable,
  input  wire logic   presence_gate_en,
  input  wire logic   peer_present,
  output logic        probing,
  output logic        full_supply_on,
  output logic        sink_mode,
  output logic        source_mode,
  output logic        send_source_caps,
  // Link side
  dbbd_link_if.dev    link
);

  // Sequencer steps; IDLE re-arms the interval timer
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_INTERVAL,
    ST_PROBE,
    ST_DISCHARGE,
    ST_FULL,
    ST_SOURCE,
    ST_SINK
  } dbbd_dev_state_e;

  // All state in one register; one timer serves every timed step
  typedef struct packed {
    dbbd_dev_state_e         state;
    logic [`DBBD_CNT_W-1:0]  timer;
    logic [7:0]              alt_cnt;
    logic                    last_bit;
    logic                    pattern_seen;
    logic                    caps_pulse;
  } dbbd_dev_s;

  // Registered state and its next value
  dbbd_dev_s st_r;
  dbbd_dev_s st_nxt;

  // Next state of the whole sequencer
  always_comb begin
    st_nxt = st_r;
    st_nxt.caps_pulse = 1'b0;
    if (st_r.state == ST_PROBE || st_r.state == ST_FULL) begin
      if (link.pattern_en && (link.pattern_bit != st_r.last_bit)) begin
        // Saturate so a long pattern cannot wrap
        if (st_r.alt_cnt != 8'hFF) begin
          st_nxt.alt_cnt = st_r.alt_cnt + 8'h01;
        end
      end else begin
        st_nxt.alt_cnt = 8'h00;
      end
      // Stale bit on entry costs one count at most
      st_nxt.last_bit = link.pattern_bit;
    end else begin
      st_nxt.alt_cnt = 8'h00;
    end
    // Extra register stage: one cycle late, short compare path
    st_nxt.pattern_seen = (32'(st_r.alt_cnt) >= PATTERN_MIN_BITS);
    if (st_r.timer != '0) begin
      st_nxt.timer = st_r.timer - `DBBD_CNT_W'(1);
    end
    case (st_r.state)
      ST_IDLE: begin
        if (enable) begin
          st_nxt.state = ST_WAIT_INTERVAL;
          st_nxt.timer = `DBBD_CNT_W'(PROBE_INTERVAL_CYC);
        end
      end
      ST_WAIT_INTERVAL: begin
        if (link.vbus_above_discharged) begin
          st_nxt.state = ST_SINK;
        end else if (st_r.timer == '0) begin
          if (!presence_gate_en || peer_present) begin
            st_nxt.state = ST_PROBE;
            st_nxt.timer = `DBBD_CNT_W'(PATTERN_WAIT_CYC);
          end else begin
            // Gate closed: re-arm and look again later
            st_nxt.timer = `DBBD_CNT_W'(PROBE_INTERVAL_CYC);
          end
        end
      end
      ST_PROBE: begin
        if (st_r.pattern_seen) begin
          st_nxt.state = ST_FULL;
          st_nxt.timer = `DBBD_CNT_W'(READY_WAIT_CYC);
        // probe bounded by wait timer
        // Late answer is only caught on the next probe
        end else if (st_r.timer == '0) begin
          st_nxt.state = ST_DISCHARGE;
          st_nxt.timer = `DBBD_CNT_W'(DISCHARGE_CYC);
        end
      end
      ST_DISCHARGE: begin
        if (st_r.timer == '0) begin
          st_nxt.state = ST_IDLE;
        end
      end
      ST_FULL: begin
        if (!link.pattern_en) begin
          st_nxt.state = ST_SOURCE;
          st_nxt.caps_pulse = 1'b1;
        end else if (st_r.timer == '0) begin
          // Peer never got ready; back off
          st_nxt.state = ST_DISCHARGE;
          st_nxt.timer = `DBBD_CNT_W'(DISCHARGE_CYC);
        end
      end
      ST_SOURCE: begin
        // Source until the user drops enable
        if (!enable) begin
          st_nxt.state = ST_IDLE;
        end
      end
      ST_SINK: begin
        // Back to probing once VBUS falls away
        if (!link.vbus_above_discharged) begin
          st_nxt.state = ST_IDLE;
        end
      end
      default: begin
        st_nxt.state = ST_IDLE;
      end
    endcase
    // Dropping enable parks the sequencer at once
    if (!enable && st_r.state != ST_IDLE) begin
      st_nxt.state = ST_IDLE;
      st_nxt.timer = '0;
    end
  end

  // State register, synchronous reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '{state: ST_IDLE, timer: '0, alt_cnt: 8'h00, last_bit: 1'b0,
                pattern_seen: 1'b0, caps_pulse: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Drive decoded from state only, so no glitch between levels
  // probe level only in probe state
  always_comb begin
    case (st_r.state)
      ST_PROBE: link.dev_drive = dbbd_pkg::DBBD_LVL_PROBE;
      ST_FULL,
      ST_SOURCE: link.dev_drive = dbbd_pkg::DBBD_LVL_FULL;
      default: link.dev_drive = dbbd_pkg::DBBD_LVL_NONE;
    endcase
  end

  // Status outputs decoded from state; send_source_caps taken from the caps_pulse register bit
  assign link.dev_discharge = (st_r.state == ST_DISCHARGE);
  assign probing            = (st_r.state == ST_PROBE);
  assign full_supply_on     = (st_r.state == ST_FULL) || (st_r.state == ST_SOURCE);
  assign sink_mode          = (st_r.state == ST_SINK);
  assign source_mode        = (st_r.state == ST_SOURCE);
  assign send_source_caps   = st_r.caps_pulse;

endmodule : dbbd_dev

/* File: hw/dbbd_host.sv */
// Unpowered end: answers the probe with the pattern, then goes quiet

`include "dbbd_defs.svh"

module dbbd_host #(
  parameter int unsigned START_DEADLINE_CYC = `DBBD_START_DEADLINE_CYC,
  parameter int unsigned POWER_WAIT_CYC     = `DBBD_POWER_WAIT_CYC
) (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   sys_rst,
  // User side
  input  wire logic   wants_power,
  input  wire logic   willing_source,
  input  wire logic   logic_ready,
  output logic        power_up_rest,
  output logic        sourcing,
  output logic        pattern_active,
  // Link side
  dbbd_link_if.host   link
);

  typedef enum logic [2:0] {
    HS_WAIT,
    HS_POWERING,
    HS_PATTERN,
    HS_READY_WAIT,
    HS_CONSUMER,
    HS_SOURCE
  } dbbd_host_state_e;

  typedef struct packed {
    dbbd_host_state_e        state;
    logic [`DBBD_CNT_W-1:0]  timer;
    logic                    bit_val;
  } dbbd_host_s;

  dbbd_host_s st_r;
  dbbd_host_s st_nxt;

  // Next state; start delay fixed at one cycle, well inside the deadline
  always_comb begin
    st_nxt = st_r;
    if (st_r.timer != '0) begin
      st_nxt.timer = st_r.timer - `DBBD_CNT_W'(1);
    end
    st_nxt.bit_val = ~st_r.bit_val;
    case (st_r.state)
      HS_WAIT: begin
        if (!link.vbus_probe_level && willing_source) begin
          st_nxt.state = HS_SOURCE;
        end else if (link.vbus_probe_level && wants_power) begin
          st_nxt.state = HS_POWERING;
          st_nxt.timer = `DBBD_CNT_W'(START_DEADLINE_CYC);
        end
      end
      HS_POWERING: begin
        st_nxt.state = HS_PATTERN;
        st_nxt.timer = `DBBD_CNT_W'(POWER_WAIT_CYC);
      end
      HS_PATTERN: begin
        if (st_r.timer == '0) begin
          st_nxt.state = HS_READY_WAIT;
        end
      end
      HS_READY_WAIT: begin
        if (logic_ready) begin
          st_nxt.state = HS_CONSUMER;
        end
      end
      HS_CONSUMER: begin
      end
      HS_SOURCE: begin
      end
      default: begin
        st_nxt.state = HS_WAIT;
      end
    endcase
    // VBUS gone while consuming: start over
    if (!link.vbus_above_discharged && st_r.state != HS_WAIT
        && st_r.state != HS_SOURCE) begin
      st_nxt.state = HS_WAIT;
    end
  end

  // State register, synchronous reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '{state: HS_WAIT, timer: '0, bit_val: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.host_drive  = (st_r.state == HS_SOURCE) ? dbbd_pkg::DBBD_LVL_FULL
                                                      : dbbd_pkg::DBBD_LVL_NONE;
  assign link.pattern_en  = (st_r.state == HS_PATTERN) || (st_r.state == HS_READY_WAIT);
  assign link.pattern_bit = st_r.bit_val;
  assign pattern_active   = link.pattern_en;
  assign power_up_rest    = (st_r.state == HS_READY_WAIT) || (st_r.state == HS_CONSUMER);
  assign sourcing         = (st_r.state == HS_SOURCE);

endmodule : dbbd_host

/* File: hw/dbbd_link_if.sv */
// Interface joining the backpowering end and the unpowered end
interface dbbd_link_if;
  // Level each end drives onto VBUS
  dbbd_pkg::dbbd_level_e dev_drive;
  dbbd_pkg::dbbd_level_e host_drive;
  logic                  dev_discharge;
  // Pattern bit sent by the unpowered end
  logic                  pattern_bit;
  logic                  pattern_en;
  // Resolved sense of VBUS, worked out by the bench
  logic                  vbus_above_discharged;
  logic                  vbus_probe_level;
  logic                  vbus_full_supply_level;

  modport dev (
    output dev_drive,
    output dev_discharge,
    input  pattern_bit,
    input  pattern_en,
    input  vbus_above_discharged,
    input  vbus_full_supply_level
  );
  modport host (
    output host_drive,
    output pattern_bit,
    output pattern_en,
    input  vbus_above_discharged,
    input  vbus_probe_level,
    input  vbus_full_supply_level
  );
endinterface : dbbd_link_if

/* File: hw/dbbd_pkg.sv */
// Types shared by both ends of the probe link
package dbbd_pkg;
  // VBUS drive level on the wire
  typedef enum logic [1:0] {
    DBBD_LVL_NONE,
    DBBD_LVL_PROBE,
    DBBD_LVL_FULL
  } dbbd_level_e;
endpackage : dbbd_pkg
